// ### src/dfc_map.svh
// register offsets, field positions, reset values and packet layout constants
`ifndef DFC_MAP_SVH
`define DFC_MAP_SVH

// register byte offsets
`define DFC_ADDR_CTRL        8'h00
`define DFC_ADDR_STATUS      8'h04
`define DFC_ADDR_DCRED       8'h08
`define DFC_ADDR_CCRED       8'h0C

// control fields and reset values
`define DFC_CTRL_DW_BIT      0
`define DFC_CTRL_RETRY_BIT   1
`define DFC_CTRL_RESET       2'h0

// status fields
`define DFC_STAT_DW_BIT      0
`define DFC_STAT_STOP_BIT    1
`define DFC_STAT_FULL_BIT    2

// bus answers
`define DFC_RESP_OKAY        2'h0
`define DFC_RESP_DECERR      2'h3

// credit counter geometry
`define DFC_CRED_W           6
`define DFC_CRED_MAX         6'h3F
`define DFC_FIELD_MAX_DW     5'h1F
`define DFC_FIELD_MAX_64     5'h03
`define DFC_CMD_MAX          6'h03

// link packet layout, bit-time n in bits [8n+7:8n]
`define DFC_NOP_CMD          6'h00
`define DFC_NOP_DISC_BIT     6
`define DFC_FIFO_DEPTH       16
`define DFC_NOP_W            32

`endif

// ### src/dfc_pkg.sv
// types shared by the credit block
package dfc_pkg;
    typedef enum logic [1:0] {DFC_CLS_POSTED, DFC_CLS_NONPOSTED, DFC_CLS_RESPONSE} dfc_class_t;
    typedef enum logic {DFC_MODE_64B, DFC_MODE_DW} dfc_mode_t;
    typedef enum logic {DFC_TX_IDLE, DFC_TX_GRANT} dfc_tx_state_t;
endpackage

// ### src/dfc_fifo.sv
// synchronous valid/ready fifo holding received credit packets
`timescale 1ns/100ps
module dfc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];

    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= '0;
            in_ready  <= 1'b0;
        end else begin
            count_reg <= count_next;
            // ready is a flop so full never depends on the filler's valid
            in_ready  <= (count_next != (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end
endmodule // dfc_fifo

// ### src/dfc_top.sv
// doubleword/64-byte data buffer credit tracking with a register slave
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "dfc_map.svh"
module dfc_top (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // register bus
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // link control
    input  wire logic        warm_rst,
    input  wire logic        link_stop_n,
    output logic             dw_mode_active,
    // received credit packets
    input  wire logic        nop_valid,
    output logic             nop_ready,
    input  wire logic [31:0] nop_data,
    // transmit requests
    input  wire logic        tx_valid,
    input  wire logic [1:0]  tx_class,
    input  wire logic        tx_has_data,
    input  wire logic [4:0]  tx_dwords,
    input  wire logic        tx_byte_write,
    output logic             tx_grant,
    // receive buffer freeing and credit packet generation
    input  wire logic        free_valid,
    input  wire logic [1:0]  free_class,
    input  wire logic        free_has_data,
    input  wire logic [4:0]  free_dwords,
    input  wire logic        free_byte_write,
    input  wire logic        nop_gen_req,
    output logic             nop_out_valid,
    output logic [31:0]      nop_out_data
);
    localparam int NCLS = 3;

    logic [`DFC_CRED_W-1:0] data_cred_reg [NCLS];
    logic [`DFC_CRED_W-1:0] cmd_cred_reg  [NCLS];
    logic [`DFC_CRED_W-1:0] free_data_reg [NCLS];
    logic [`DFC_CRED_W-1:0] free_cmd_reg  [NCLS];
    logic [4:0]             data_inc      [NCLS];
    logic [1:0]             cmd_inc       [NCLS];
    logic [4:0]             rep_data      [NCLS];
    logic [1:0]             rep_cmd       [NCLS];
    logic [4:0]             enc_data      [NCLS];
    logic [1:0]             ctrl_reg;
    dfc_pkg::dfc_mode_t     mode_reg;
    dfc_pkg::dfc_tx_state_t tx_state_reg;
    logic [2:0]             stop_sync_reg;
    logic                   stopped_reg;
    logic [31:0]            fifo_data;
    logic                   fifo_valid;
    logic                   nop_pop;
    logic                   nop_is_credit;
    logic [`DFC_CRED_W-1:0] tx_need;
    logic                   tx_take;
    logic [`DFC_CRED_W-1:0] free_amt;
    logic                   nop_send;
    logic [4:0]             field_max;
    logic [7:0]             aw_addr_reg;
    logic [31:0]            w_data_reg;
    logic [3:0]             w_strb_reg;
    logic                   aw_held_reg;
    logic                   w_held_reg;
    logic [31:0]            rd_word;
    logic                   rd_hit;

    function automatic logic [`DFC_CRED_W-1:0] sat_add(
        input logic [`DFC_CRED_W-1:0] a,
        input logic [`DFC_CRED_W-1:0] b
    );
        logic [`DFC_CRED_W:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        // clamping holds the sum at the six-bit maximum instead of wrapping
        sat_add = sum[`DFC_CRED_W] ? `DFC_CRED_MAX : sum[`DFC_CRED_W-1:0];
    endfunction

    assign dw_mode_active = (mode_reg == dfc_pkg::DFC_MODE_DW);

    dfc_fifo #(
        .WIDTH (`DFC_NOP_W),
        .DEPTH (`DFC_FIFO_DEPTH)
    ) u_nop_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (nop_valid),
        .in_ready  (nop_ready),
        .in_data   (nop_data),
        .out_valid (fifo_valid),
        .out_ready (nop_pop),
        .out_data  (fifo_data)
    );

    // stop pin: three flops, level taken once the last two agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_sync_reg <= 3'h7;
            stopped_reg   <= 1'b0;
        end else begin
            stop_sync_reg <= {stop_sync_reg[1:0], link_stop_n};
            if (stop_sync_reg[1] == stop_sync_reg[2]) begin
                stopped_reg <= !stop_sync_reg[2];
            end
        end
    end

    // mode latched only at warm reset; a stop never touches it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= dfc_pkg::DFC_MODE_64B;
        end else if (warm_rst) begin
            if (ctrl_reg[`DFC_CTRL_DW_BIT] && !ctrl_reg[`DFC_CTRL_RETRY_BIT]) begin
                mode_reg <= dfc_pkg::DFC_MODE_DW;
            end else begin
                mode_reg <= dfc_pkg::DFC_MODE_64B;
            end
        end
    end

    // received credit packet decode; a stopped link drains nothing
    assign nop_pop       = fifo_valid && !stopped_reg;
    assign nop_is_credit = nop_pop && (fifo_data[5:0] == `DFC_NOP_CMD);

    always_comb begin
        if (dw_mode_active) begin
            data_inc[dfc_pkg::DFC_CLS_RESPONSE]  = {fifo_data[15:14], fifo_data[22],
                                                    fifo_data[31:30]};
            data_inc[dfc_pkg::DFC_CLS_POSTED]    = {fifo_data[11:10], fifo_data[29:27]};
            data_inc[dfc_pkg::DFC_CLS_NONPOSTED] = {fifo_data[19:18], fifo_data[26:24]};
        end else begin
            data_inc[dfc_pkg::DFC_CLS_RESPONSE]  = {3'h0, fifo_data[15:14]};
            data_inc[dfc_pkg::DFC_CLS_POSTED]    = {3'h0, fifo_data[11:10]};
            data_inc[dfc_pkg::DFC_CLS_NONPOSTED] = {3'h0, fifo_data[19:18]};
        end
        cmd_inc[dfc_pkg::DFC_CLS_RESPONSE]  = fifo_data[13:12];
        cmd_inc[dfc_pkg::DFC_CLS_POSTED]    = fifo_data[9:8];
        cmd_inc[dfc_pkg::DFC_CLS_NONPOSTED] = fifo_data[17:16];
    end

    // transmit need: mask dword is data in dword mode, one buffer otherwise
    always_comb begin
        if (!tx_has_data) begin
            tx_need = '0;
        end else if (dw_mode_active) begin
            tx_need = {1'b0, tx_dwords} + {5'h00, tx_byte_write};
        end else begin
            tx_need = 6'h01;
        end
    end

    assign tx_take = (tx_state_reg == dfc_pkg::DFC_TX_IDLE) && tx_valid && !stopped_reg
                     && !warm_rst && (tx_class != 2'h3)
                     && (data_cred_reg[tx_class] >= tx_need)
                     && (cmd_cred_reg[tx_class] != '0);

    // grant is one pulse; the GRANT state during it blocks a new take while the requester drops valid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_state_reg <= dfc_pkg::DFC_TX_IDLE;
            tx_grant     <= 1'b0;
        end else begin
            case (tx_state_reg)
                dfc_pkg::DFC_TX_IDLE: begin
                    tx_grant <= tx_take;
                    if (tx_take) begin
                        tx_state_reg <= dfc_pkg::DFC_TX_GRANT;
                    end
                end
                default: begin
                    tx_grant     <= 1'b0;
                    tx_state_reg <= dfc_pkg::DFC_TX_IDLE;
                end
            endcase
        end
    end

    // six-bit transmit counters; only a warm reset moves them while the link is stopped
    always_ff @(posedge aclk) begin
        if (!aresetn || warm_rst) begin
            for (int i = 0; i < NCLS; i++) begin
                data_cred_reg[i] <= '0;
                cmd_cred_reg[i]  <= '0;
            end
        end else if (!stopped_reg) begin
            for (int i = 0; i < NCLS; i++) begin
                data_cred_reg[i] <= sat_add(data_cred_reg[i],
                                            nop_is_credit ? {1'b0, data_inc[i]} : 6'h00)
                                    - ((tx_take && tx_class == 2'(i)) ? tx_need : 6'h00);
                cmd_cred_reg[i]  <= sat_add(cmd_cred_reg[i],
                                            nop_is_credit ? {4'h0, cmd_inc[i]} : 6'h00)
                                    - ((tx_take && tx_class == 2'(i)) ? 6'h01 : 6'h00);
            end
        end
    end

    // receive side: freed buffers gathered, then reported in a credit packet
    assign free_amt  = !free_has_data ? 6'h00 :
                       dw_mode_active ? ({1'b0, free_dwords} + {5'h00, free_byte_write}) : 6'h01;
    assign field_max = dw_mode_active ? `DFC_FIELD_MAX_DW : `DFC_FIELD_MAX_64;
    assign nop_send  = nop_gen_req && !stopped_reg && !warm_rst;

    always_comb begin
        for (int i = 0; i < NCLS; i++) begin
            rep_data[i] = (free_data_reg[i] > {1'b0, field_max}) ? field_max
                                                                 : free_data_reg[i][4:0];
            rep_cmd[i]  = (free_cmd_reg[i] > `DFC_CMD_MAX) ? 2'h3 : free_cmd_reg[i][1:0];
            // 64-byte credits sit in the upper two bits of the wide field
            enc_data[i] = dw_mode_active ? rep_data[i] : {rep_data[i][1:0], 3'h0};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || warm_rst) begin
            for (int i = 0; i < NCLS; i++) begin
                free_data_reg[i] <= '0;
                free_cmd_reg[i]  <= '0;
            end
        end else begin
            for (int i = 0; i < NCLS; i++) begin
                free_data_reg[i] <= sat_add(free_data_reg[i] - (nop_send ? {1'b0, rep_data[i]}
                                                                         : 6'h00),
                                            (free_valid && free_class == 2'(i)) ? free_amt
                                                                                : 6'h00);
                free_cmd_reg[i]  <= sat_add(free_cmd_reg[i] - (nop_send ? {4'h0, rep_cmd[i]}
                                                                        : 6'h00),
                                            (free_valid && free_class == 2'(i)) ? 6'h01
                                                                                : 6'h00);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nop_out_valid <= 1'b0;
            nop_out_data  <= 32'h0000_0000;
        end else begin
            nop_out_valid <= nop_send;
            if (nop_send) begin
                nop_out_data <= {enc_data[dfc_pkg::DFC_CLS_RESPONSE][1:0],
                                 enc_data[dfc_pkg::DFC_CLS_POSTED][2:0],
                                 enc_data[dfc_pkg::DFC_CLS_NONPOSTED][2:0],
                                 1'b0, enc_data[dfc_pkg::DFC_CLS_RESPONSE][2], 2'h0,
                                 enc_data[dfc_pkg::DFC_CLS_NONPOSTED][4:3],
                                 rep_cmd[dfc_pkg::DFC_CLS_NONPOSTED],
                                 enc_data[dfc_pkg::DFC_CLS_RESPONSE][4:3],
                                 rep_cmd[dfc_pkg::DFC_CLS_RESPONSE],
                                 enc_data[dfc_pkg::DFC_CLS_POSTED][4:3],
                                 rep_cmd[dfc_pkg::DFC_CLS_POSTED],
                                 1'b0, 1'b0, `DFC_NOP_CMD};
            end
        end
    end

    // register bus: write address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg   <= s_axi_awaddr;
                aw_held_reg   <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                w_held_reg   <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_held_reg && w_held_reg && !s_axi_bvalid) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `DFC_RESP_OKAY;
            ctrl_reg     <= `DFC_CTRL_RESET;
        end else if (aw_held_reg && w_held_reg && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr_reg[7:2] == `DFC_ADDR_CTRL >> 2) begin
                s_axi_bresp <= `DFC_RESP_OKAY;
                // takes effect at the next warm reset only
                if (w_strb_reg[0]) begin
                    ctrl_reg <= w_data_reg[1:0];
                end
            end else if (aw_addr_reg[7:2] == `DFC_ADDR_STATUS >> 2
                         || aw_addr_reg[7:2] == `DFC_ADDR_DCRED >> 2
                         || aw_addr_reg[7:2] == `DFC_ADDR_CCRED >> 2) begin
                s_axi_bresp <= `DFC_RESP_OKAY;
            end else begin
                s_axi_bresp <= `DFC_RESP_DECERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        if (s_axi_araddr[7:2] == `DFC_ADDR_CTRL >> 2) begin
            rd_word[1:0] = ctrl_reg;
        end else if (s_axi_araddr[7:2] == `DFC_ADDR_STATUS >> 2) begin
            rd_word[`DFC_STAT_DW_BIT]   = dw_mode_active;
            rd_word[`DFC_STAT_STOP_BIT] = stopped_reg;
            rd_word[`DFC_STAT_FULL_BIT] = !nop_ready;
        end else if (s_axi_araddr[7:2] == `DFC_ADDR_DCRED >> 2) begin
            rd_word = {10'h000, data_cred_reg[2], 2'h0, data_cred_reg[1], 2'h0,
                       data_cred_reg[0]};
        end else if (s_axi_araddr[7:2] == `DFC_ADDR_CCRED >> 2) begin
            rd_word = {10'h000, cmd_cred_reg[2], 2'h0, cmd_cred_reg[1], 2'h0,
                       cmd_cred_reg[0]};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `DFC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? `DFC_RESP_OKAY : `DFC_RESP_DECERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence grant_seq;
        tx_grant ##1 !tx_grant;
    endsequence

    cold_mode_a: assert property ($past(!aresetn) |-> !dw_mode_active)
        else $error("not in 64-byte mode after cold reset");
    mode_hold_a: assert property (!warm_rst |=> $stable(mode_reg))
        else $error("mode changed without warm reset");
    retry_block_a: assert property (warm_rst && ctrl_reg[`DFC_CTRL_RETRY_BIT]
                                    |=> !dw_mode_active)
        else $error("dword mode entered under retry mode");
    stop_hold_a: assert property (stopped_reg && !warm_rst |=> $stable(data_cred_reg[0])
                                  && $stable(data_cred_reg[1]) && $stable(data_cred_reg[2])
                                  && $stable(free_data_reg[0]) && !nop_out_valid)
        else $error("credit state moved while stopped");
    cred_sat_a: assert property (data_cred_reg[0] == `DFC_CRED_MAX && !tx_take && !warm_rst
                                 && !stopped_reg |=> data_cred_reg[0] == `DFC_CRED_MAX)
        else $error("posted credit counter wrapped");
    grant_cover_a: assert property (tx_take |-> data_cred_reg[tx_class] >= tx_need
                                    ##1 grant_seq)
        else $error("grant without enough credit or not one pulse");
    mask_dword_a: assert property (tx_take && dw_mode_active && tx_byte_write && tx_has_data
                                   |-> tx_need == {1'b0, tx_dwords} + 6'h01)
        else $error("byte mask dword not counted");
    coarse_need_a: assert property (tx_take && !dw_mode_active |-> tx_need <= 6'h01)
        else $error("64-byte mode consumed more than one buffer");
    nop_cmd_a: assert property (nop_out_valid |-> nop_out_data[5:0] == `DFC_NOP_CMD
                                && !nop_out_data[`DFC_NOP_DISC_BIT])
        else $error("credit packet command field wrong");
    coarse_field_a: assert property (nop_out_valid && !dw_mode_active
                                     |-> nop_out_data[31:24] == 8'h00
                                     && !nop_out_data[22])
        else $error("low credit bits set in 64-byte mode");
endmodule // dfc_top

// ### testbench/dfc_peer_model.sv
// far-end link partner: packs and sends credit packets
`timescale 1ns/100ps
module dfc_peer_model (
    // clock
    input  wire logic        aclk,
    // credit packet stream
    input  wire logic        nop_ready,
    output logic             nop_valid,
    output logic [31:0]      nop_data
);
    initial begin
        nop_valid = 1'b0;
        nop_data  = 32'h0;
    end
    // layout of bit-times 0..3, diag/isoc/disconnect kept clear
    function automatic logic [31:0] nop(input logic [4:0] r, p, n, input logic [1:0] rc, pc, nc);
        return {r[1:0], p[2:0], n[2:0], 1'b0, r[2], 2'b00, n[4:3], nc,
                r[4:3], rc, p[4:3], pc, 8'h00};
    endfunction
    // released data shows the inverse, so no stale word looks valid
    task automatic send(input logic [31:0] d);
        nop_valid <= 1'b1;
        nop_data  <= d;
        do @(posedge aclk); while (!nop_ready);
        nop_valid <= 1'b0;
        nop_data  <= ~d;
        @(posedge aclk);
    endtask
endmodule // dfc_peer_model

// ### testbench/dfc_top_tb.sv
// self-checking bench for the credit block
`timescale 1ns/100ps
`include "dfc_map.svh"
module dfc_top_tb;
    logic aclk=0, aresetn=0, s_axi_awvalid=0, s_axi_wvalid=0, s_axi_bready=0, s_axi_arvalid=0;
    logic s_axi_rready=0, warm_rst=0, link_stop_n=1, tx_valid=0, tx_has_data=0, tx_byte_write=0;
    logic free_valid=0, free_has_data=0, free_byte_write=0, nop_gen_req=0;
    logic [7:0]  s_axi_awaddr=8'h00, s_axi_araddr=8'h00;
    logic [31:0] s_axi_wdata=32'h0, s_axi_rdata, nop_data, nop_out_data, rd;
    logic [3:0]  s_axi_wstrb=4'hF;
    logic [1:0]  tx_class=2'h0, free_class=2'h0, s_axi_bresp, s_axi_rresp, rr, br;
    logic [4:0]  tx_dwords=5'h00, free_dwords=5'h00;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic dw_mode_active, nop_valid, nop_ready, tx_grant, nop_out_valid;
    int   failures = 0;
    int   cmp_count = 0;
    dfc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .warm_rst(warm_rst), .link_stop_n(link_stop_n),
        .dw_mode_active(dw_mode_active), .nop_valid(nop_valid), .nop_ready(nop_ready),
        .nop_data(nop_data), .tx_valid(tx_valid), .tx_class(tx_class), .tx_has_data(tx_has_data),
        .tx_dwords(tx_dwords), .tx_byte_write(tx_byte_write), .tx_grant(tx_grant),
        .free_valid(free_valid), .free_class(free_class), .free_has_data(free_has_data),
        .free_dwords(free_dwords), .free_byte_write(free_byte_write), .nop_gen_req(nop_gen_req),
        .nop_out_valid(nop_out_valid), .nop_out_data(nop_out_data));
    dfc_peer_model u_peer (.aclk(aclk), .nop_ready(nop_ready), .nop_valid(nop_valid),
                           .nop_data(nop_data));
    always #50 aclk = ~aclk;
    task automatic test_done();
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 0;
        tw = 0;
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin ta = 1; s_axi_awvalid <= 0; end
            if (s_axi_wvalid && s_axi_wready) begin tw = 1; s_axi_wvalid <= 0; end
        end
        s_axi_bready <= 1;
        do @(posedge aclk); while (!s_axi_bvalid);
        br = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic axr(input logic [7:0] a);
        s_axi_araddr <= a; s_axi_arvalid <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0; s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd = s_axi_rdata; rr = s_axi_rresp; s_axi_rready <= 0;
    endtask
    task automatic send_tx(input logic [1:0] c, input logic [4:0] n, input logic bw);
        tx_valid <= 1; tx_class <= c; tx_dwords <= n; tx_byte_write <= bw; tx_has_data <= 1;
        do @(posedge aclk); while (!tx_grant);
        tx_valid <= 0;
        @(posedge aclk);
    endtask
    task automatic warm();
        warm_rst <= 1; @(posedge aclk); warm_rst <= 0; @(posedge aclk);
    endtask
    // free one request (n dwords plus bw in dword mode, one buffer in 64-byte mode), then ask for a credit packet and wait for it
    task automatic free_nop(input logic [1:0] c, input logic [4:0] n, input logic bw);
        free_valid <= 1; free_class <= c; free_dwords <= n; free_has_data <= 1;
        free_byte_write <= bw; @(posedge aclk);
        free_valid <= 0; nop_gen_req <= 1; @(posedge aclk);
        nop_gen_req <= 0;
        do @(posedge aclk); while (!nop_out_valid);
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1; @(posedge aclk);
        axr(`DFC_ADDR_STATUS); chk("status after reset", rd, 32'h0);
        axr(8'h10); chk("unmapped resp", {30'h0, rr}, 32'h3);
        axw(8'h10, 32'h0); chk("unmapped write resp", {30'h0, br}, 32'h3);
        u_peer.send(u_peer.nop(5'h18, 5'h10, 5'h08, 2'h3, 2'h3, 2'h3));
        repeat (3) @(posedge aclk);
        axr(`DFC_ADDR_DCRED); chk("64b data credits", rd, 32'h00030102);
        axr(`DFC_ADDR_CCRED); chk("64b cmd credits", rd, 32'h00030303);
        send_tx(2'h0, 5'h04, 1'b0);
        axr(`DFC_ADDR_DCRED); chk("64b after send", rd, 32'h00030101);
        link_stop_n <= 0; repeat (5) @(posedge aclk);
        repeat (16) u_peer.send(32'h0);
        chk("fifo refuses", {31'h0, nop_ready}, 32'h0);
        axr(`DFC_ADDR_STATUS); chk("stopped full", rd, 32'h6);
        axr(`DFC_ADDR_DCRED); chk("credits across stop", rd, 32'h00030101);
        link_stop_n <= 1; repeat (30) @(posedge aclk);
        axw(`DFC_ADDR_CTRL, 32'h1); chk("ctrl write resp", {30'h0, br}, 32'h0);
        axr(`DFC_ADDR_STATUS); chk("no switch without warm", rd, 32'h0);
        warm();
        axr(`DFC_ADDR_STATUS); chk("dw after warm", rd, 32'h1);
        chk("dw mode pin", {31'h0, dw_mode_active}, 32'h1);
        axr(`DFC_ADDR_DCRED); chk("cleared by warm", rd, 32'h0);
        repeat (3) u_peer.send(32'hFF4FFF00);
        repeat (3) @(posedge aclk);
        axr(`DFC_ADDR_DCRED); chk("dw saturate", rd, 32'h003F3F3F);
        send_tx(2'h1, 5'h10, 1'b1);
        axr(`DFC_ADDR_DCRED); chk("dw send mask", rd, 32'h003F2E3F);
        free_nop(2'h0, 5'h04, 1'b1);
        chk("freed posted dw", {27'h0, nop_out_data[11:10], nop_out_data[29:27]}, 32'h5);
        axw(`DFC_ADDR_CTRL, 32'h3); warm();
        axr(`DFC_ADDR_STATUS); chk("retry blocks dw", rd, 32'h0);
        free_nop(2'h0, 5'h04, 1'b0);
        chk("freed posted 64b", {27'h0, nop_out_data[11:10], nop_out_data[29:27]}, 32'h8);
        chk("freed posted cmd", {30'h0, nop_out_data[9:8]}, 32'h1);
        test_done();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        test_done();
    end
endmodule // dfc_top_tb
